/* src/ssp_pkg.sv */
// package: constants shared by both ends of the strap-select serial port
package ssp_pkg;
  // ==========================================================================
  // device register map
  localparam logic [14:0] REG_SPI_CFG  = 15'h0000;
  localparam logic [14:0] REG_RB_SEL   = 15'h0001;
  localparam logic [14:0] REG_COMMIT   = 15'h000F;
  localparam int          CFG_LSB_BIT  = 6;
  localparam int          CFG_LSB_MIR  = 1;
  localparam int          CFG_ASC_BIT  = 5;
  localparam int          CFG_ASC_MIR  = 2;
  localparam int          RB_SEL_BIT   = 5;
  localparam int          COMMIT_BIT   = 0;
  localparam logic [7:0]  CFG_RST      = 8'h00;
  localparam logic [7:0]  UNMAPPED_VAL = 8'h00;
  localparam logic [3:0]  INSTR_LAST   = 4'hF;
  localparam logic [2:0]  BYTE_LAST    = 3'h7;

  // ==========================================================================
  // three-level strap coding and port-select decode
  localparam logic [1:0]  LVL_LOW       = 2'h0;
  localparam logic [1:0]  LVL_HIGH      = 2'h1;
  localparam logic [1:0]  LVL_FLOAT     = 2'h2;
  localparam logic [3:0]  SEL_SPI_LOAD  = 4'h0;
  localparam logic [3:0]  SEL_SPI       = 4'h8;
  localparam logic [6:0]  I2C_ADDR_BASE = 7'h38;

  // ==========================================================================
  // host command registers
  localparam logic [4:0]  HREG_CMD       = 5'h00;
  localparam logic [4:0]  HREG_ADDR      = 5'h01;
  localparam logic [4:0]  HREG_LEN       = 5'h02;
  localparam logic [4:0]  HREG_STAT      = 5'h03;
  localparam int          HREG_DATA_BIT  = 4;
  localparam int          HCMD_GO        = 0;
  localparam int          HCMD_RD        = 1;
  localparam int          HCMD_LSB       = 2;
  localparam int          HOST_BUF_BYTES = 8;
  localparam logic [6:0]  INSTR_BITS     = 7'h10;

  // ==========================================================================
  // timing
  localparam int MCLK_PERIOD_NS = 8;
  localparam int SCLK_PERIOD_NS = 128;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
endpackage : ssp_pkg

/* src/ssp_if.sv */
// interface: three-wire serial link between host and device
`timescale 1ns/1ps
interface ssp_if;
  logic sclk;
  logic cs_n;
  logic host_sdo;
  logic host_sdo_oe;
  logic dev_sdo;
  logic dev_sdo_oe;
  logic sdio;

  // ==========================================================================
  // shared data wire, weak pull-up when nobody drives
  assign sdio = dev_sdo_oe ? dev_sdo : (host_sdo_oe ? host_sdo : 1'b1);

  modport host (output sclk, output cs_n, output host_sdo, output host_sdo_oe, input sdio);
  modport dev  (input sclk, input cs_n, input sdio, output dev_sdo, output dev_sdo_oe);
endinterface : ssp_if

/* src/ssp_sync.sv */
// two-flop synchroniser for pins and foreign-clock levels
`timescale 1ns/1ps
module ssp_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } ssp_sync_state_t;

  ssp_sync_state_t s_r;
  ssp_sync_state_t s_nxt;

  // ==========================================================================
  // meta stage feeds only the second stage
  always_comb
  begin
    s_nxt.meta = d_i;
    s_nxt.q    = s_r.meta;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      s_r <= {RST, RST};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.q;
endmodule : ssp_sync

/* src/ssp_device.sv */
// device end: strap-selected three-wire serial configuration port
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
// Overview of operation
// - supplies good: scan straps, load registers
// - prescalers held until own loop locks
// - protocol fixed at scan, reset only changes
// - decode two three-level port-select straps
// - capture on sclk rise, drive on fall
// - one bidirectional data pin only
// - cs fall starts, bytes stream, cs rise ends
// - data pin released while cs high
// - address steps after every payload byte
// - sixteen-bit instruction precedes payload
// - read/write flag first, then fifteen-bit address
// - commit bit copies buffer to active, self-clears
// - read streams bytes from start address
// - no address skipped during read-back
// - read source chosen by select bit
// - MSB first default, config selects LSB first
// - no single-byte instruction mode
// - port config register lives in port logic
// - ascension bits choose increment or decrement
module ssp_device #(
  parameter int STRAP_W = 8,
  parameter int MAP_N   = 32
) (
  input  wire logic                 mclk_i,
  input  wire logic                 reset_i,
  ssp_if.dev                        spi,
  input  wire logic                 supply_ok_i,
  input  wire logic                 ldo_ok_i,
  input  wire logic [1:0]           port_select_strap_low_i,
  input  wire logic [1:0]           port_select_strap_high_i,
  input  wire logic [STRAP_W-1:0]   config_strap_pins_i,
  input  wire logic                 lock_detect_fractional_loop_i,
  input  wire logic                 lock_detect_integer_loop_i,
  output logic                      port_is_spi_o,
  output logic                      strap_load_o,
  output logic [6:0]                i2c_addr_o,
  output logic [STRAP_W-1:0]        strap_cfg_o,
  output logic [1:0]                prescale_run_o,
  output logic [MAP_N*8-1:0]        active_regs_o
);
  localparam int AW = $clog2(MAP_N);
  localparam int SW = STRAP_W + 11;

  typedef enum logic [1:0] {ST_POR, ST_SPI, ST_I2C} ssp_dev_st_t;

  typedef struct packed {
    ssp_dev_st_t               st;
    logic                      spi_mode;
    logic                      strap_load;
    logic [6:0]                i2c_addr;
    logic [STRAP_W-1:0]        strap_cfg;
    logic [1:0]                pre_run;
    logic                      sclk_q;
    logic                      payload;
    logic                      rd;
    logic [3:0]                bcnt;
    logic [14:0]               addr;
    logic [15:0]               sr;
    logic [7:0]                tx;
    logic                      sdo;
    logic                      sdo_oe;
    logic [7:0]                cfg;
    logic                      rb_sel;
    logic [MAP_N-1:0][7:0]     bufm;
    logic [MAP_N-1:0][7:0]     actm;
  } ssp_dev_state_t;

  ssp_dev_state_t     s_r;
  ssp_dev_state_t     s_nxt;
  logic [SW-1:0]      sy;
  logic               sy_sup;
  logic               sy_ldo;
  logic [1:0]         sy_splo;
  logic [1:0]         sy_sphi;
  logic [STRAP_W-1:0] sy_strap;
  logic               sy_lk0;
  logic               sy_lk1;
  logic               sy_sdio;
  logic               sy_sclk;
  logic               sy_cs_n;
  logic               rise;
  logic               fall;
  logic               lsb;
  logic [3:0]         sel;
  logic [7:0]         din;
  logic [15:0]        t16;

  // ==========================================================================
  // every pin passes two flops; cs_n idles high
  ssp_sync #(
    .W   (SW),
    .RST (SW'(1))
  ) u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .d_i     ({supply_ok_i, ldo_ok_i, port_select_strap_low_i, port_select_strap_high_i,
               config_strap_pins_i, lock_detect_fractional_loop_i,
               lock_detect_integer_loop_i, spi.sdio, spi.sclk, spi.cs_n}),
    .q_o     (sy)
  );

  assign {sy_sup, sy_ldo, sy_splo, sy_sphi, sy_strap, sy_lk0, sy_lk1, sy_sdio, sy_sclk,
          sy_cs_n} = sy;

  // ==========================================================================
  // helpers
  function automatic logic [1:0] lvl_idx(input logic [1:0] lvl);
    lvl_idx = (lvl == ssp_pkg::LVL_LOW) ? 2'h1 : ((lvl == ssp_pkg::LVL_HIGH) ? 2'h2 : 2'h0);
  endfunction : lvl_idx

  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++)
    begin
      rev16[i] = v[15-i];
    end
  endfunction : rev16

  // blank and unmapped addresses still answer, so a stream never skips
  function automatic logic [7:0] read_byte(input ssp_dev_state_t st, input logic [14:0] a);
    if (a == ssp_pkg::REG_SPI_CFG)
      read_byte = st.cfg;
    else if (a == ssp_pkg::REG_RB_SEL)
      read_byte = {2'h0, st.rb_sel, 5'h00};
    else if (a == ssp_pkg::REG_COMMIT)
      read_byte = 8'h00;
    else if (a < 15'(MAP_N))
      read_byte = st.rb_sel ? st.actm[a[AW-1:0]] : st.bufm[a[AW-1:0]];
    else
      read_byte = ssp_pkg::UNMAPPED_VAL;
  endfunction : read_byte

  // ==========================================================================
  // next state
  always_comb
  begin
    s_nxt    = s_r;
    rise     = sy_sclk & ~s_r.sclk_q;
    fall     = ~sy_sclk & s_r.sclk_q;
    lsb      = s_r.cfg[ssp_pkg::CFG_LSB_BIT];
    sel      = 4'h0;
    din      = 8'h00;
    t16      = 16'h0000;
    s_nxt.sclk_q  = sy_sclk;
    s_nxt.pre_run = 2'h0;
    case (s_r.st)
      ST_POR:
      begin
        if (sy_sup && sy_ldo)
        begin
          sel = 4'(lvl_idx(sy_splo)) * 4'h3 + 4'(lvl_idx(sy_sphi));
          s_nxt.strap_load = (sel == ssp_pkg::SEL_SPI_LOAD);
          s_nxt.spi_mode   = (sel == ssp_pkg::SEL_SPI_LOAD) || (sel == ssp_pkg::SEL_SPI);
          s_nxt.i2c_addr   = s_nxt.spi_mode ? 7'h00 : ssp_pkg::I2C_ADDR_BASE + {3'h0, sel};
          s_nxt.strap_cfg  = (sel == ssp_pkg::SEL_SPI) ? '0 : sy_strap;
          s_nxt.st         = s_nxt.spi_mode ? ST_SPI : ST_I2C;
        end
      end
      ST_SPI:
      begin
        if (sy_cs_n)
        begin
          s_nxt.bcnt    = 4'h0;
          s_nxt.payload = 1'b0;
          s_nxt.sdo_oe  = 1'b0;
        end
        else
        begin
          if (rise)
          begin
            s_nxt.sr   = {s_r.sr[14:0], sy_sdio};
            s_nxt.bcnt = s_r.bcnt + 4'h1;
            if (!s_r.payload)
            begin
              if (s_r.bcnt == ssp_pkg::INSTR_LAST)
              begin
                t16           = rev16({1'b0, s_nxt.sr[14:0]});
                s_nxt.payload = 1'b1;
                s_nxt.bcnt    = 4'h0;
                s_nxt.rd      = s_nxt.sr[15];
                s_nxt.addr    = lsb ? t16[15:1] : s_nxt.sr[14:0];
                s_nxt.tx      = read_byte(s_r, s_nxt.addr);
              end
            end
            else if (s_r.bcnt[2:0] == ssp_pkg::BYTE_LAST)
            begin
              t16        = rev16({8'h00, s_nxt.sr[7:0]});
              din        = lsb ? t16[15:8] : s_nxt.sr[7:0];
              s_nxt.bcnt = 4'h0;
              if (!s_r.rd)
              begin
                if (s_r.addr == ssp_pkg::REG_SPI_CFG)
                begin
                  s_nxt.cfg = din;
                  s_nxt.cfg[ssp_pkg::CFG_LSB_BIT] = din[ssp_pkg::CFG_LSB_BIT] |
                                                    din[ssp_pkg::CFG_LSB_MIR];
                  s_nxt.cfg[ssp_pkg::CFG_LSB_MIR] = s_nxt.cfg[ssp_pkg::CFG_LSB_BIT];
                  s_nxt.cfg[ssp_pkg::CFG_ASC_BIT] = din[ssp_pkg::CFG_ASC_BIT] |
                                                    din[ssp_pkg::CFG_ASC_MIR];
                  s_nxt.cfg[ssp_pkg::CFG_ASC_MIR] = s_nxt.cfg[ssp_pkg::CFG_ASC_BIT];
                end
                else if (s_r.addr == ssp_pkg::REG_RB_SEL)
                  s_nxt.rb_sel = din[ssp_pkg::RB_SEL_BIT];
                else if (s_r.addr == ssp_pkg::REG_COMMIT)
                begin
                  // trigger bit is never stored, so it always reads back 0
                  if (din[ssp_pkg::COMMIT_BIT])
                    s_nxt.actm = s_r.bufm;
                end
                else if (s_r.addr < 15'(MAP_N))
                  s_nxt.bufm[s_r.addr[AW-1:0]] = din;
              end
              s_nxt.addr = s_r.cfg[ssp_pkg::CFG_ASC_BIT] ? s_r.addr + 15'h0001
                                                         : s_r.addr - 15'h0001;
              s_nxt.tx   = read_byte(s_nxt, s_nxt.addr);
            end
          end
          // the single pin turns round only in a read payload
          if (fall && s_r.payload && s_r.rd)
          begin
            s_nxt.sdo_oe = 1'b1;
            s_nxt.sdo    = lsb ? s_r.tx[s_r.bcnt[2:0]]
                               : s_r.tx[ssp_pkg::BYTE_LAST - s_r.bcnt[2:0]];
          end
        end
      end
      ST_I2C:
      begin
        s_nxt.sdo_oe = 1'b0;
      end
      default:
      begin
        s_nxt.st = ST_POR;
      end
    endcase
    if (s_r.st != ST_POR)
      s_nxt.pre_run = {sy_lk1, sy_lk0};
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      s_r     <= '0;
      s_r.cfg <= ssp_pkg::CFG_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // outputs straight from state flops
  assign spi.dev_sdo    = s_r.sdo;
  assign spi.dev_sdo_oe = s_r.sdo_oe;
  assign port_is_spi_o  = s_r.spi_mode;
  assign strap_load_o   = s_r.strap_load;
  assign i2c_addr_o     = s_r.i2c_addr;
  assign strap_cfg_o    = s_r.strap_cfg;
  assign prescale_run_o = s_r.pre_run;
  assign active_regs_o  = s_r.actm;
endmodule : ssp_device

/* src/ssp_host.sv */
// host end: register-driven three-wire serial master
`timescale 1ns/1ps
module ssp_host #(
  parameter int SCLK_HALF = ssp_pkg::SCLK_HALF_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  ssp_if.host              spi,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  output logic             busy_o
);
  localparam int NB = ssp_pkg::HOST_BUF_BYTES;

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_TAIL, H_END} ssp_host_st_t;

  typedef struct packed {
    ssp_host_st_t          st;
    logic                  rw;
    logic                  lsb;
    logic [14:0]           addr;
    logic [3:0]            len;
    logic [6:0]            cnt;
    logic [7:0]            div;
    logic                  sclk;
    logic                  cs_n;
    logic                  sdo;
    logic                  sdo_oe;
    logic [15:0]           rdata;
    logic [NB-1:0][7:0]    mem;
  } ssp_host_state_t;

  ssp_host_state_t s_r;
  ssp_host_state_t s_nxt;
  logic            sy_sdio;
  logic            tick;
  logic [6:0]      pos;
  logic [2:0]      bsel;
  logic [6:0]      total;

  // ==========================================================================
  // read data comes from the device, so it is synchronised too
  ssp_sync #(
    .W   (1),
    .RST (1'b1)
  ) u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .d_i     (spi.sdio),
    .q_o     (sy_sdio)
  );

  // bit sent before rise number i: flag, address, then payload
  function automatic logic host_bit(input ssp_host_state_t h, input logic [6:0] i);
    logic [6:0] p;
    logic [3:0] k;
    p = i - ssp_pkg::INSTR_BITS;
    k = i[3:0];
    if (i == 7'h00)
      host_bit = h.rw;
    else if (i < ssp_pkg::INSTR_BITS)
      host_bit = h.lsb ? h.addr[k - 4'h1] : h.addr[4'hF - k];
    else
      host_bit = h.lsb ? h.mem[p[5:3]][p[2:0]] : h.mem[p[5:3]][3'h7 - p[2:0]];
  endfunction : host_bit

  // ==========================================================================
  // next state
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.rdata = 16'h0000;
    tick        = (s_r.div == 8'(SCLK_HALF - 1));
    pos         = s_r.cnt - ssp_pkg::INSTR_BITS;
    bsel        = s_r.lsb ? pos[2:0] : 3'h7 - pos[2:0];
    total       = ssp_pkg::INSTR_BITS + {s_r.len, 3'h0};
    s_nxt.div   = tick ? 8'h00 : s_r.div + 8'h01;
    case (s_r.st)
      H_IDLE:
      begin
        s_nxt.div = 8'h00;
      end
      H_SHIFT:
      begin
        if (tick && !s_r.sclk)
        begin
          s_nxt.sclk = 1'b1;
          if (s_r.rw && s_r.cnt >= ssp_pkg::INSTR_BITS)
            s_nxt.mem[pos[5:3]][bsel] = sy_sdio;
          s_nxt.cnt = s_r.cnt + 7'h01;
          if (s_nxt.cnt == total)
            s_nxt.st = H_TAIL;
        end
        else if (tick)
        begin
          s_nxt.sclk = 1'b0;
          if (s_r.rw && s_r.cnt >= ssp_pkg::INSTR_BITS)
            s_nxt.sdo_oe = 1'b0;
          else
            s_nxt.sdo = host_bit(s_r, s_r.cnt);
        end
      end
      H_TAIL:
      begin
        if (tick)
        begin
          s_nxt.sclk = 1'b0;
          s_nxt.st   = H_END;
        end
      end
      H_END:
      begin
        if (tick)
        begin
          s_nxt.cs_n   = 1'b1;
          s_nxt.sdo_oe = 1'b0;
          s_nxt.st     = H_IDLE;
        end
      end
      default:
      begin
        s_nxt.st = H_IDLE;
      end
    endcase
    // settings are frozen while a transfer runs
    if (reg_wr_i && s_r.st == H_IDLE)
    begin
      if (reg_addr_i[ssp_pkg::HREG_DATA_BIT])
        s_nxt.mem[reg_addr_i[2:0]] = reg_wdata_i[7:0];
      else if (reg_addr_i == ssp_pkg::HREG_ADDR)
        s_nxt.addr = reg_wdata_i[14:0];
      else if (reg_addr_i == ssp_pkg::HREG_LEN)
        s_nxt.len = (reg_wdata_i[3:0] > 4'(NB)) ? 4'(NB) : reg_wdata_i[3:0];
      else if (reg_addr_i == ssp_pkg::HREG_CMD && reg_wdata_i[ssp_pkg::HCMD_GO])
      begin
        s_nxt.rw     = reg_wdata_i[ssp_pkg::HCMD_RD];
        s_nxt.lsb    = reg_wdata_i[ssp_pkg::HCMD_LSB];
        s_nxt.st     = H_SHIFT;
        s_nxt.cs_n   = 1'b0;
        s_nxt.sclk   = 1'b0;
        s_nxt.cnt    = 7'h00;
        s_nxt.div    = 8'h00;
        s_nxt.sdo_oe = 1'b1;
        s_nxt.sdo    = reg_wdata_i[ssp_pkg::HCMD_RD];
      end
    end
    if (reg_rd_i)
    begin
      if (reg_addr_i[ssp_pkg::HREG_DATA_BIT])
        s_nxt.rdata = {8'h00, s_r.mem[reg_addr_i[2:0]]};
      else if (reg_addr_i == ssp_pkg::HREG_CMD)
        s_nxt.rdata = {13'h0000, s_r.lsb, s_r.rw, 1'b0};
      else if (reg_addr_i == ssp_pkg::HREG_ADDR)
        s_nxt.rdata = {1'b0, s_r.addr};
      else if (reg_addr_i == ssp_pkg::HREG_LEN)
        s_nxt.rdata = {12'h000, s_r.len};
      else if (reg_addr_i == ssp_pkg::HREG_STAT)
        s_nxt.rdata = {15'h0000, s_r.st != H_IDLE};
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      s_r      <= '0;
      s_r.cs_n <= 1'b1;
      s_r.len  <= 4'h1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // outputs straight from state flops, except busy_o, which is decoded from st
  assign spi.sclk        = s_r.sclk;
  assign spi.cs_n        = s_r.cs_n;
  assign spi.host_sdo    = s_r.sdo;
  assign spi.host_sdo_oe = s_r.sdo_oe;
  assign reg_rdata_o     = s_r.rdata;
  assign busy_o          = s_r.st != H_IDLE;
endmodule : ssp_host

/* test/ssp_properties.sv */
// checker: link-level properties of the serial port
`timescale 1ns/1ps
module ssp_properties (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic host_sdo,
  input wire logic host_sdo_oe,
  input wire logic dev_sdo,
  input wire logic dev_sdo_oe
);
  logic       sclk_r;
  logic [7:0] rise_r;

  // ==========================================================================
  // sclk rises since select; cleared while idle
  always_ff @(posedge mclk_i)
  begin
    sclk_r <= sclk;
    if (reset_i || cs_n)
      rise_r <= 8'h00;
    else if (sclk && !sclk_r)
      rise_r <= rise_r + 8'h01;
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  // ==========================================================================
  // sequences
  sequence s_idle;
    $rose(cs_n) ##1 cs_n [*5];
  endsequence
  sequence s_start;
    $fell(cs_n);
  endsequence

  // ==========================================================================
  // properties
  a_pin_released: assert property (s_idle |-> !dev_sdo_oe)
    else $error("device drives sdio while deselected");
  a_single_driver: assert property (!(dev_sdo_oe && host_sdo_oe))
    else $error("both ends drive sdio");
  a_clock_idle: assert property (cs_n |-> !sclk)
    else $error("sclk high while deselected");
  a_start_quiet: assert property (s_start |-> !sclk && host_sdo_oe)
    else $error("frame opened with sclk high or host silent");
  a_host_setup: assert property ($rose(sclk) && host_sdo_oe |-> $stable(host_sdo))
    else $error("host data moved at sclk rise");
  a_dev_on_fall: assert property (dev_sdo_oe && $past(dev_sdo_oe) && $changed(dev_sdo)
    |-> !sclk)
    else $error("device data moved while sclk high");
  a_turn_after16: assert property ($rose(dev_sdo_oe) |-> !cs_n && rise_r == 8'h10)
    else $error("read data not after sixteenth rise");
  a_frame_whole: assert property ($rose(cs_n) |-> rise_r >= 8'h10 && rise_r[2:0] == 3'h0)
    else $error("frame not instruction plus whole bytes");
endmodule : ssp_properties

/* test/ssp_tb.sv */
// testbench: host and device ends joined over one link
`timescale 1ns/1ps
module ssp_tb;
  typedef struct packed {
    logic        rd;
    logic        lsb;
    logic [14:0] addr;
    logic [3:0]  len;
    logic [31:0] data;
  } ssp_row_t;

  logic        mclk_i  = 1'b0;
  logic        reset_i = 1'b1;
  logic        ldo     = 1'b0;
  logic        lk1     = 1'b0;
  logic [1:0]  sp_lo   = 2'h1;
  logic [1:0]  sp_hi   = 2'h1;
  logic [4:0]  haddr   = 5'h00;
  logic [15:0] hwdata  = 16'h0000;
  logic        hwr     = 1'b0;
  logic        hrd     = 1'b0;
  logic [15:0] hrdata;
  logic        busy_o;
  logic        port_is_spi_o;
  logic        strap_load_o;
  logic [6:0]  i2c_addr_o;
  logic [7:0]  strap_cfg_o;
  logic [1:0]  prescale_run_o;
  logic [255:0] active_regs_o;
  logic [31:0] mon_q;
  logic [15:0] q;
  logic [14:0] aa;
  logic [14:0] dd;
  ssp_row_t    r;
  int          mon_n;
  int          idx;
  int          bad_count = 0;
  int          cmp_count = 0;
  // rd/lsb, address, byte count, bytes (first in low byte)
  ssp_row_t rows [15] = '{
    {2'b00, 15'h0005, 4'h3, 32'h00C3B2A1}, {2'b10, 15'h0005, 4'h3, 32'h00C3B2A1},
    {2'b00, 15'h000F, 4'h1, 32'h00000001}, {2'b00, 15'h0000, 4'h1, 32'h00000024},
    {2'b00, 15'h0006, 4'h2, 32'h00002211}, {2'b10, 15'h0006, 4'h2, 32'h00002211},
    {2'b00, 15'h0001, 4'h1, 32'h00000020}, {2'b10, 15'h0005, 4'h1, 32'h000000A1},
    {2'b10, 15'h0006, 4'h1, 32'h00000000}, {2'b00, 15'h0000, 4'h1, 32'h00000066},
    {2'b01, 15'h0009, 4'h1, 32'h0000005A}, {2'b01, 15'h000F, 4'h1, 32'h00000001},
    {2'b11, 15'h0009, 4'h2, 32'h0000005A}, {2'b11, 15'h000F, 4'h1, 32'h00000000},
    {2'b11, 15'h0000, 4'h1, 32'h00000066}};

  ssp_if link ();
  ssp_host ssp_host_inst (.mclk_i(mclk_i), .reset_i(reset_i), .spi(link), .reg_addr_i(haddr),
    .reg_wdata_i(hwdata), .reg_wr_i(hwr), .reg_rd_i(hrd), .reg_rdata_o(hrdata), .busy_o(busy_o));
  ssp_device ssp_device_inst (.mclk_i(mclk_i), .reset_i(reset_i), .spi(link), .supply_ok_i(1'b1),
    .ldo_ok_i(ldo), .port_select_strap_low_i(sp_lo), .port_select_strap_high_i(sp_hi),
    .config_strap_pins_i(8'hA5), .lock_detect_fractional_loop_i(1'b1),
    .lock_detect_integer_loop_i(lk1), .port_is_spi_o(port_is_spi_o),
    .strap_load_o(strap_load_o), .i2c_addr_o(i2c_addr_o), .strap_cfg_o(strap_cfg_o),
    .prescale_run_o(prescale_run_o), .active_regs_o(active_regs_o));
  ssp_properties ssp_properties_inst (.mclk_i(mclk_i), .reset_i(reset_i), .sclk(link.sclk),
    .cs_n(link.cs_n), .host_sdo(link.host_sdo), .host_sdo_oe(link.host_sdo_oe),
    .dev_sdo(link.dev_sdo), .dev_sdo_oe(link.dev_sdo_oe));

  initial
  begin
    forever #4 mclk_i = ~mclk_i;
  end

  // ==========================================================================
  // wire monitor: every bit seen at an sclk rise while selected
  always @(negedge link.cs_n) mon_n = 0;
  always @(posedge link.sclk)
  begin
    if (!link.cs_n)
    begin
      mon_q = {mon_q[30:0], link.sdio};
      mon_n++;
    end
  end

  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    haddr <= a;
    hwdata <= d;
    hwr <= 1'b1;
    @(posedge mclk_i);
    hwr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [4:0] a);
    @(posedge mclk_i);
    haddr <= a;
    hrd <= 1'b1;
    @(posedge mclk_i);
    hrd <= 1'b0;
    #1 q = hrdata;
  endtask : reg_rd

  // bounded: a stuck link would otherwise hang the run
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge mclk_i);
    while (busy_o !== 1'b0 && n < 9000)
    begin
      @(posedge mclk_i);
      n++;
    end
    if (n == 9000)
    begin
      bad_count++;
      $display("wrong value at %0t: link hung", $time);
      test_done();
    end
  endtask : wait_idle

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    chk(32'(port_is_spi_o), 32'h0);
    chk(32'(prescale_run_o), 32'h0);
    ldo <= 1'b1;
    for (int lo = 0; lo < 3; lo++)
      for (int hi = 0; hi < 3; hi++)
      begin
        sp_lo <= 2'(lo);
        sp_hi <= 2'(hi);
        reset_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (20) @(posedge mclk_i);
        idx = (lo == 2 ? 0 : lo + 1) * 3 + (hi == 2 ? 0 : hi + 1);
        chk(32'({port_is_spi_o, strap_load_o, i2c_addr_o, strap_cfg_o}), 32'({idx % 8 == 0,
          idx == 0, idx % 8 == 0 ? 7'h00 : 7'h38 + 7'(idx), idx == 8 ? 8'h00 : 8'hA5}));
      end
    chk(32'(prescale_run_o), 32'h1);
    sp_lo <= 2'h0;
    sp_hi <= 2'h0;
    lk1 <= 1'b1;
    repeat (10) @(posedge mclk_i);
    chk(32'({port_is_spi_o, i2c_addr_o}), 32'h80);
    chk(32'(prescale_run_o), 32'h3);
    for (int i = 0; i < 15; i++)
    begin
      r = rows[i];
      reg_wr(5'h01, {1'b0, r.addr});
      reg_wr(5'h02, {12'h000, r.len});
      for (int j = 0; j < 3; j++)
        reg_wr(5'h10 + 5'(j), {8'h00, r.data[8*j +: 8] ^ {8{r.rd}}});
      reg_wr(5'h00, {13'h0000, r.lsb, r.rd, 1'b1});
      wait_idle();
      chk(32'(mon_n), 32'(16 + 8 * int'(r.len)));
      aa = r.lsb ? rev(r.addr, 15) : r.addr;
      dd = r.lsb ? rev(15'(r.data[7:0]), 8) : 15'(r.data[7:0]);
      if (r.len == 4'h1)
        chk({8'h00, mon_q[23:0]}, {8'h00, r.rd, aa, dd[7:0]});
      if (i == 0)
        chk(32'(active_regs_o[47:40]), 32'h0);
      for (int j = 0; j < int'(r.len) && r.rd; j++)
      begin
        reg_rd(5'h10 + 5'(j));
        chk({16'h0000, q}, {24'h000000, r.data[8*j +: 8]});
      end
    end
    chk(32'({active_regs_o[47:40], active_regs_o[79:72]}), 32'hA15A);
    reg_wr(5'h02, 16'h000F);
    reg_rd(5'h02);
    chk({16'h0000, q}, 32'h8);
    test_done();
  end

  function automatic logic [14:0] rev(input logic [14:0] v, input int n);
    logic [14:0] o;
    o = 15'h0000;
    for (int k = 0; k < n; k++)
      o[k] = v[n-1-k];
    return o;
  endfunction : rev
endmodule : ssp_tb
